/* gpsr_pkg.sv */
// Purpose: Constants for the gigabit PHY status register bank
// Assumes: 16-bit management data, register index addressing
// Notes:   Offsets are register indices on the management port
package gpsr_pkg;
    localparam logic [4:0]  ADDR_LINK_STATUS  = 5'h0a;
    localparam logic [4:0]  ADDR_RSVD_PSE     = 5'h0b;
    localparam logic [4:0]  ADDR_IRQ_STATUS   = 5'h1c;
    localparam logic [4:0]  ADDR_IRQ_MASK     = 5'h1d;
    localparam logic [15:0] RESET_LINK_STATUS = 16'h0000;
    localparam logic [15:0] RESET_RSVD        = 16'h0000;
    localparam logic [2:0]  RESET_IRQ_MASK    = 3'h0;
    localparam int          BIT_FAULT         = 15;
    localparam int          BIT_RESOLUTION    = 14;
    localparam int          BIT_LOCAL_OK      = 13;
    localparam int          BIT_REMOTE_OK     = 12;
    localparam int          BIT_PARTNER_FD    = 11;
    localparam int          BIT_PARTNER_HD    = 10;
    localparam logic [2:0]  FAIL_LIMIT        = 3'h7;
    localparam logic [7:0]  COUNT_MAX         = 8'hff;
    localparam int          IRQ_FAULT         = 0;
    localparam int          IRQ_COUNT_SAT     = 1;
    localparam int          IRQ_LINK_CHANGE   = 2;
endpackage

/* gpsr_idle_counter.sv */
// Purpose: Saturating idle error counter, cleared on read or PCS reset
// Assumes: i_symbol is one pulse per symbol period
// Notes:   Clear has priority; a clear loses the error of that cycle
`timescale 1ns/10ps
module gpsr_idle_counter (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    input  wire logic       i_symbol,
    input  wire logic       i_send_n,
    input  wire logic       i_idle,
    input  wire logic       i_rx_error,
    output logic [7:0]      o_count,
    output logic            o_saturated
);
    typedef struct packed {
        logic [7:0] count;
        logic       sat_pulse;
    } gpsr_cnt_s;

    gpsr_cnt_s state;
    gpsr_cnt_s next_state;
    logic      count_en;

    ////////////////////////////////////////////////////////////////////////
    // Counting only during idles in SEND_N mode
    assign count_en = i_symbol && i_idle && i_send_n && i_rx_error;

    always_comb begin
        next_state = state;
        next_state.sat_pulse = 1'b0;
        if (i_clear) begin
            next_state.count = 8'h00;
        end else if (count_en && state.count != gpsr_pkg::COUNT_MAX) begin
            next_state.count = state.count + 8'h01;
            next_state.sat_pulse = (state.count == gpsr_pkg::COUNT_MAX - 8'h01);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_count = state.count;
    assign o_saturated = state.sat_pulse;

    a_count_holds_max: assert property (@(posedge i_clk) disable iff (i_rst)
        (state.count == gpsr_pkg::COUNT_MAX && !i_clear) |=> state.count == gpsr_pkg::COUNT_MAX)
        else $error("idle error count left saturation");
    a_count_steps_one: assert property (@(posedge i_clk) disable iff (i_rst)
        (count_en && !i_clear && state.count != gpsr_pkg::COUNT_MAX)
        |=> state.count == $past(state.count) + 8'h01)
        else $error("idle error count did not step by one");
    a_count_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
        i_clear |=> state.count == 8'h00)
        else $error("idle error count not cleared");
    a_count_gated: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_clear && !(i_send_n && i_idle)) |=> $stable(state.count))
        else $error("idle error count moved outside SEND_N idles");
endmodule

/* gpsr_status_regs.sv */
// Purpose: Gigabit link status register and reserved neighbour register
// Assumes: Status inputs come from the same clock domain as i_clk
// Notes:   Reads answer one cycle after the read strobe
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module gpsr_status_regs (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_pcs_reset,
    input  wire logic        i_an_enable,
    input  wire logic        i_an_complete,
    input  wire logic        i_ms_fail,
    input  wire logic        i_ms_master,
    input  wire logic        i_local_rx_ok,
    input  wire logic        i_remote_rx_ok,
    input  wire logic        i_partner_fd,
    input  wire logic        i_partner_hd,
    input  wire logic        i_symbol,
    input  wire logic        i_idle,
    input  wire logic        i_rx_error,
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [15:0]      o_rdata,
    output logic             o_irq
);
    typedef struct packed {
        logic [2:0]  fail_count;
        logic        fault;
        logic        an_enable_d;
        logic        link_ok_d;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [15:0] rdata;
    } gpsr_regs_s;

    gpsr_regs_s  state;
    gpsr_regs_s  next_state;
    logic [7:0]  idle_count;
    logic        count_sat;
    logic        status_read;
    logic        send_n;
    logic        link_ok;
    logic        fault_clear_auto;
    logic        fault_set;
    logic [15:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_read_of(input logic [4:0] addr, input logic [4:0] target);
        is_read_of = (addr == target);
    endfunction

    assign status_read = i_rd && is_read_of(i_addr, gpsr_pkg::ADDR_LINK_STATUS);
    assign send_n = i_local_rx_ok && i_remote_rx_ok;
    assign link_ok = send_n;
    // Auto-clear on the rising edge of enable and on completion
    assign fault_clear_auto = (i_an_enable && !state.an_enable_d) || i_an_complete;
    assign fault_set = i_ms_fail && state.fail_count == gpsr_pkg::FAIL_LIMIT - 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Idle error counter
    gpsr_idle_counter u_idle_counter (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_clear     (status_read || i_pcs_reset),
        .i_symbol    (i_symbol),
        .i_send_n    (send_n),
        .i_idle      (i_idle),
        .i_rx_error  (i_rx_error),
        .o_count     (idle_count),
        .o_saturated (count_sat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live view of the status word; the fault bit is the latched copy
    always_comb begin
        status_word = gpsr_pkg::RESET_LINK_STATUS;
        status_word[gpsr_pkg::BIT_FAULT]      = state.fault;
        status_word[gpsr_pkg::BIT_RESOLUTION] = i_ms_master;
        status_word[gpsr_pkg::BIT_LOCAL_OK]   = i_local_rx_ok;
        status_word[gpsr_pkg::BIT_REMOTE_OK]  = i_remote_rx_ok;
        status_word[gpsr_pkg::BIT_PARTNER_FD] = i_partner_fd;
        status_word[gpsr_pkg::BIT_PARTNER_HD] = i_partner_hd;
        status_word[7:0] = idle_count;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: fault latch, fail counter, interrupt, read data
    always_comb begin
        next_state = state;
        next_state.an_enable_d = i_an_enable;
        next_state.link_ok_d = link_ok;
        // Fail counter restarts with each negotiation, stops at the limit
        if (fault_clear_auto) begin
            next_state.fail_count = 3'h0;
        end else if (i_ms_fail && state.fail_count != gpsr_pkg::FAIL_LIMIT) begin
            next_state.fail_count = state.fail_count + 3'h1;
        end
        // Set beats the read clear so a fault in the read cycle survives
        if (fault_set) begin
            next_state.fault = 1'b1;
        end else if (fault_clear_auto || status_read) begin
            next_state.fault = 1'b0;
        end
        // PCS reset clears negotiation history but keeps software setup
        if (i_pcs_reset) begin
            next_state.fail_count = 3'h0;
            next_state.fault = 1'b0;
        end
        // Read data is sampled from pre-clear values
        next_state.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                gpsr_pkg::ADDR_LINK_STATUS: begin
                    next_state.rdata = status_word;
                end
                gpsr_pkg::ADDR_RSVD_PSE: begin
                    next_state.rdata = gpsr_pkg::RESET_RSVD;
                end
                gpsr_pkg::ADDR_IRQ_STATUS: begin
                    next_state.rdata = {13'h0000, state.irq_status};
                end
                gpsr_pkg::ADDR_IRQ_MASK: begin
                    next_state.rdata = {13'h0000, state.irq_mask};
                end
                default: begin
                    next_state.rdata = 16'h0000;
                end
            endcase
        end
        // Sticky events; read of the status clears, new events win
        if (i_rd && is_read_of(i_addr, gpsr_pkg::ADDR_IRQ_STATUS)) begin
            next_state.irq_status = 3'h0;
        end
        if (fault_set) begin
            next_state.irq_status[gpsr_pkg::IRQ_FAULT] = 1'b1;
        end
        if (count_sat) begin
            next_state.irq_status[gpsr_pkg::IRQ_COUNT_SAT] = 1'b1;
        end
        if (link_ok != state.link_ok_d) begin
            next_state.irq_status[gpsr_pkg::IRQ_LINK_CHANGE] = 1'b1;
        end
        // Writes to status and reserved words are dropped
        if (i_wr && i_addr == gpsr_pkg::ADDR_IRQ_MASK) begin
            next_state.irq_mask = i_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_irq = |(state.irq_status & state.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_status_read;
        i_rd && i_addr == gpsr_pkg::ADDR_LINK_STATUS;
    endsequence

    // Read of the interrupt status word
    sequence s_irq_read;
        i_rd && i_addr == gpsr_pkg::ADDR_IRQ_STATUS;
    endsequence

    // Write of the interrupt mask word
    sequence s_mask_write;
        i_wr && i_addr == gpsr_pkg::ADDR_IRQ_MASK;
    endsequence

    // PCS reset must wipe the negotiation history in one cycle
    a_pcs_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        i_pcs_reset |=> (!state.fault && state.fail_count == 3'h0))
        else $error("PCS reset left fault history behind");
    // A saturated fail counter must not wrap and fire a second fault
    a_fail_saturates: assert property (@(posedge i_clk) disable iff (i_rst)
        (state.fail_count == gpsr_pkg::FAIL_LIMIT && !fault_clear_auto && !i_pcs_reset)
        |=> state.fail_count == gpsr_pkg::FAIL_LIMIT)
        else $error("fail counter wrapped");
    // Rising edge of negotiation enable clears the flag
    a_enable_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_an_enable && !state.an_enable_d && !fault_set) |=> !state.fault)
        else $error("fault flag not cleared by negotiation enable");
    // Read data stands for one cycle only, then returns to zero
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data present without a read");
    // Reading the event word clears it unless a new event lands
    a_irq_read_clr: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_irq_read and (!fault_set && !count_sat && link_ok == state.link_ok_d))
        |=> state.irq_status == 3'h0)
        else $error("interrupt status survived its read");
    // Mask takes the written bits
    a_mask_written: assert property (@(posedge i_clk) disable iff (i_rst)
        s_mask_write |=> state.irq_mask == $past(i_wdata[2:0]))
        else $error("interrupt mask not written");
    // A fault event must be recorded for the interrupt line
    a_fault_event: assert property (@(posedge i_clk) disable iff (i_rst)
        fault_set |=> state.irq_status[gpsr_pkg::IRQ_FAULT])
        else $error("fault event not recorded");

    a_fault_latches: assert property (@(posedge i_clk) disable iff (i_rst)
        (state.fault && !status_read && !fault_clear_auto && !i_pcs_reset) |=> state.fault)
        else $error("fault flag dropped without a clear");
    a_fault_read_clr: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_status_read and (!fault_set)) |=> !state.fault)
        else $error("fault flag survived a status read");
    a_fault_auto_clr: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_an_complete && !fault_set) |=> !state.fault)
        else $error("fault flag not cleared by negotiation");
    a_fault_seventh: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ms_fail && state.fail_count == 3'h6 && !i_pcs_reset) |=> state.fault)
        else $error("fault flag not set at seventh failure");
    a_read_preclear: assert property (@(posedge i_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[gpsr_pkg::BIT_FAULT] == $past(state.fault)
                          && o_rdata[7:0] == $past(idle_count))
        else $error("status read did not return pre-clear values");
    a_live_bits: assert property (@(posedge i_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[14:10] == $past({i_ms_master, i_local_rx_ok,
                                                   i_remote_rx_ok, i_partner_fd, i_partner_hd}))
        else $error("live status bits misreported");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == gpsr_pkg::ADDR_RSVD_PSE) |=> o_rdata == 16'h0000)
        else $error("reserved register read non-zero");
    a_rsvd_bits_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        s_status_read |=> o_rdata[9:8] == 2'b00)
        else $error("reserved status bits non-zero");
endmodule

/* gpsr_status_regs_bench.sv */
// Purpose: Self-checking bench for the gigabit link status register bank
// Assumes: Single 100 MHz clock, all stimulus launched at rising edges
// Notes:   Interrupt registers at 0x1c and 0x1d are probed as well
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module gpsr_status_regs_bench;
    logic        i_clk, i_rst, i_pcs_reset, i_an_enable, i_an_complete, i_ms_fail;
    logic        i_ms_master, i_local_rx_ok, i_remote_rx_ok, i_partner_fd, i_partner_hd;
    logic        i_symbol, i_idle, i_rx_error, i_wr, i_rd, o_irq;
    logic [4:0]  i_addr;
    logic [15:0] i_wdata, o_rdata;
    int          err_count, total_checks;
    // Inputs master, local ok, remote ok, fd, hd beside the expected word
    typedef struct { logic [4:0] lv; logic [15:0] exp; } gpsr_row_s;
    gpsr_row_s   rows [6];
    ////////////////////////////////////////////////////////////////////////////
    gpsr_status_regs i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_pcs_reset(i_pcs_reset),
        .i_an_enable(i_an_enable), .i_an_complete(i_an_complete), .i_ms_fail(i_ms_fail),
        .i_ms_master(i_ms_master), .i_local_rx_ok(i_local_rx_ok),
        .i_remote_rx_ok(i_remote_rx_ok), .i_partner_fd(i_partner_fd),
        .i_partner_hd(i_partner_hd), .i_symbol(i_symbol), .i_idle(i_idle),
        .i_rx_error(i_rx_error), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
    ////////////////////////////////////////////////////////////////////////////
    // Free running clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Verdict in one place, shared by the main sequence and the watchdog
    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe, so sample it there
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge i_clk) begin i_rd <= 1'b1; i_addr <= a; end
        @(posedge i_clk) i_rd <= 1'b0;
        #1 `CHK(o_rdata, exp)
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    // One failed resolution or one errored symbol per two cycles
    task automatic fails(input int n);
        repeat (n) begin
            @(posedge i_clk) i_ms_fail <= 1'b1;
            @(posedge i_clk) i_ms_fail <= 1'b0;
        end
    endtask
    task automatic errs(input int n);
        repeat (n) begin
            @(posedge i_clk) i_symbol <= 1'b1;
            @(posedge i_clk) i_symbol <= 1'b0;
        end
    endtask
    task automatic pcs();
        @(posedge i_clk) i_pcs_reset <= 1'b1;
        @(posedge i_clk) i_pcs_reset <= 1'b0;
    endtask
    // Whole run is under a thousand cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_pcs_reset, i_an_enable, i_an_complete, i_ms_fail, i_symbol} = '0;
        {i_ms_master, i_local_rx_ok, i_remote_rx_ok, i_partner_fd, i_partner_hd} = '0;
        {i_idle, i_rx_error, i_wr, i_rd} = '0;
        i_addr = 5'h00;
        i_wdata = 16'h0000;
        err_count = 0;
        total_checks = 0;
        rows = '{'{5'h10, 16'h4000}, '{5'h08, 16'h2000}, '{5'h04, 16'h1000},
                 '{5'h02, 16'h0800}, '{5'h01, 16'h0400}, '{5'h1f, 16'h7c00}};
        i_rst = 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values and the reserved neighbour
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        rd(gpsr_pkg::ADDR_RSVD_PSE, 16'h0000);
        rd(gpsr_pkg::ADDR_IRQ_MASK, 16'h0000);
        // Live status bits, one row at a time
        foreach (rows[k]) begin
            @(posedge i_clk) {i_ms_master, i_local_rx_ok, i_remote_rx_ok, i_partner_fd,
                i_partner_hd} <= rows[k].lv;
            rd(gpsr_pkg::ADDR_LINK_STATUS, rows[k].exp);
        end
        // Zero writes to read-only places change nothing; unmapped reads zero
        wr(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        wr(gpsr_pkg::ADDR_RSVD_PSE, 16'h0000);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h7c00);
        rd(gpsr_pkg::ADDR_RSVD_PSE, 16'h0000);
        rd(5'h03, 16'h0000);
        // Idle errors count only with idles and both receivers ok
        @(posedge i_clk) begin i_ms_master <= 1'b0; i_partner_fd <= 1'b0; end
        @(posedge i_clk) begin i_partner_hd <= 1'b0; i_idle <= 1'b1; i_rx_error <= 1'b1; end
        errs(5);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h3005);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h3000);
        @(posedge i_clk) i_idle <= 1'b0;
        errs(2);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h3000);
        @(posedge i_clk) begin i_idle <= 1'b1; i_remote_rx_ok <= 1'b0; end
        errs(3);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h2000);
        @(posedge i_clk) i_remote_rx_ok <= 1'b1;
        errs(260);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h30ff);
        errs(4);
        pcs();
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h3000);
        // Saturation and link change latched but masked
        @(posedge i_clk) {i_local_rx_ok, i_remote_rx_ok, i_idle, i_rx_error} <= '0;
        @(posedge i_clk) #1 `CHK(o_irq, 1'b0)
        rd(gpsr_pkg::ADDR_IRQ_STATUS, 16'h0006);
        // Fault needs exactly seven failures; unmask it first
        wr(gpsr_pkg::ADDR_IRQ_MASK, 16'h0001);
        rd(gpsr_pkg::ADDR_IRQ_MASK, 16'h0001);
        fails(6);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        `CHK(o_irq, 1'b0)
        fails(1);
        @(posedge i_clk) #1 `CHK(o_irq, 1'b1)
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h8000);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        rd(gpsr_pkg::ADDR_IRQ_STATUS, 16'h0001);
        `CHK(o_irq, 1'b0)
        // Negotiation completion, then enable, clear a standing fault
        pcs();
        fails(7);
        @(posedge i_clk) i_an_complete <= 1'b1;
        @(posedge i_clk) i_an_complete <= 1'b0;
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        fails(7);
        @(posedge i_clk) i_an_enable <= 1'b1;
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        // Mid-run reset wipes mask and events; interrupt line drops
        fails(7);
        @(posedge i_clk) #1 `CHK(o_irq, 1'b1)
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        #1 `CHK(o_irq, 1'b0)
        rd(gpsr_pkg::ADDR_IRQ_MASK, 16'h0000);
        rd(gpsr_pkg::ADDR_LINK_STATUS, 16'h0000);
        report_and_stop();
    end
endmodule
